/* ctb_capture_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctb_consts.svh"

module ctb_capture_timer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Event system and partner timer
	input wire logic event_i,
	input wire logic partner_tick_i,
	input wire logic partner_restart_i,
	output logic event_o,
	// Waveform and interrupt
	output logic wave_o,
	output logic irq_o
);

	ctb_pkg::ctb_state_t s_r;
	ctb_pkg::ctb_state_t s_nxt;
	ctb_pkg::ctb_mode_t mode;
	logic tick;
	logic sig;
	logic rise;
	logic fall;
	logic start_edge;
	logic stop_edge;
	logic cap_evt;
	logic shot_trig;
	logic capture_mode;
	logic frozen;
	logic rd_cmp_hi;
	logic flag_set;
	logic flag_clr;
	logic at_top;
	logic pwm_level;

	function automatic logic [15:0] inc16(input logic [15:0] v);
		inc16 = v + 16'h0001;
	endfunction

	assign mode = ctb_pkg::ctb_mode_t'(s_r.timer_mode_select);

	// Prescaler: per clock, every second clock, or partner timer tick
	always_comb begin
		case (s_r.clock_source_select)
			`CTB_CLK_PER: tick = s_r.enable;
			`CTB_CLK_PER_DIV2: tick = s_r.enable & s_r.div;
			`CTB_CLK_PARTNER: tick = s_r.enable & partner_tick_i;
			default: tick = 1'b0;
		endcase
	end

	// Filter is on the system clock, not the prescaled one
	assign sig = s_r.filter_en ? s_r.filt_out : s_r.sync[1];
	assign rise = sig & ~s_r.prev;
	assign fall = ~sig & s_r.prev;
	assign start_edge = s_r.event_input_enable & (s_r.edge_sel ? fall : rise);
	assign stop_edge = s_r.event_input_enable & (s_r.edge_sel ? rise : fall);
	assign cap_evt = start_edge;
	assign shot_trig = s_r.event_input_enable & (s_r.edge_sel ? (rise | fall) : rise);
	assign capture_mode = (mode == ctb_pkg::CTB_MODE_CAPT_EVENT) || (mode == ctb_pkg::CTB_MODE_CAPT_FREQ) ||
		(mode == ctb_pkg::CTB_MODE_CAPT_PW) || (mode == ctb_pkg::CTB_MODE_CAPT_FREQ_PW);
	assign frozen = (mode == ctb_pkg::CTB_MODE_TIMEOUT) && !s_r.run;
	assign rd_cmp_hi = reg_rd_i && (reg_addr_i == `CTB_OFS_COMPARE_HI) && !frozen;
	assign at_top = (s_r.count_value == s_r.compare_capture_value);
	// A duty byte above a nonzero period byte keeps output high for the whole period
	assign pwm_level = (s_r.compare_capture_value[7:0] != 8'h00) && (s_r.compare_capture_value[15:8] != 8'h00) &&
		({8'h00, s_r.count_value[7:0]} < {8'h00, s_r.compare_capture_value[15:8]});

	always_comb begin
		s_nxt = s_r;
		flag_set = 1'b0;
		flag_clr = 1'b0;

		// Two-stage synchroniser, then four-sample filter
		s_nxt.sync = {s_r.sync[0], event_i};
		s_nxt.filt = {s_r.filt[2:0], s_r.sync[1]};
		if (s_r.filt == `CTB_FILTER_ALL_HIGH) begin
			s_nxt.filt_out = 1'b1;
		end else if (s_r.filt == `CTB_FILTER_ALL_LOW) begin
			s_nxt.filt_out = 1'b0;
		end
		s_nxt.prev = sig;
		s_nxt.div = s_r.enable ? ~s_r.div : 1'b0;

		if (s_r.enable) begin
			case (mode)
				ctb_pkg::CTB_MODE_PERIODIC: begin
					if (tick) begin
						if (at_top) begin
							s_nxt.count_value = 16'h0000;
							flag_set = 1'b1;
						end else begin
							s_nxt.count_value = inc16(s_r.count_value);
						end
					end
				end
				ctb_pkg::CTB_MODE_TIMEOUT: begin
					if (tick && s_r.run) begin
						s_nxt.count_value = inc16(s_r.count_value);
						if (at_top) begin
							flag_set = 1'b1;
						end
					end
					if (cap_evt) begin
						if (s_r.run) begin
							s_nxt.run = 1'b0;
						end else begin
							s_nxt.run = 1'b1;
							s_nxt.count_value = 16'h0000;
						end
					end
				end
				ctb_pkg::CTB_MODE_CAPT_EVENT: begin
					if (tick) begin
						s_nxt.count_value = inc16(s_r.count_value);
					end
					if (cap_evt) begin
						s_nxt.compare_capture_value = s_r.count_value;
						flag_set = 1'b1;
					end
				end
				ctb_pkg::CTB_MODE_CAPT_FREQ: begin
					if (tick) begin
						s_nxt.count_value = inc16(s_r.count_value);
					end
					if (cap_evt) begin
						s_nxt.compare_capture_value = s_r.count_value;
						s_nxt.count_value = 16'h0000;
						flag_set = 1'b1;
					end
				end
				ctb_pkg::CTB_MODE_CAPT_PW: begin
					if (tick) begin
						s_nxt.count_value = inc16(s_r.count_value);
					end
					if (start_edge) begin
						s_nxt.count_value = 16'h0000;
					end else if (stop_edge) begin
						s_nxt.compare_capture_value = s_r.count_value;
						flag_set = 1'b1;
					end
				end
				ctb_pkg::CTB_MODE_CAPT_FREQ_PW: begin
					if (tick && s_r.run) begin
						s_nxt.count_value = inc16(s_r.count_value);
					end
					case (s_r.fp_phase)
						ctb_pkg::CTB_FP_ARMED: begin
							if (start_edge) begin
								s_nxt.count_value = 16'h0000;
								s_nxt.run = 1'b1;
								s_nxt.fp_phase = ctb_pkg::CTB_FP_COUNTING;
							end
						end
						ctb_pkg::CTB_FP_COUNTING: begin
							if (stop_edge) begin
								s_nxt.compare_capture_value = s_r.count_value;
								s_nxt.fp_phase = ctb_pkg::CTB_FP_CAPTURED;
							end
						end
						ctb_pkg::CTB_FP_CAPTURED: begin
							if (start_edge) begin
								s_nxt.run = 1'b0;
								flag_set = 1'b1;
								s_nxt.fp_phase = ctb_pkg::CTB_FP_DONE;
							end
						end
						default: begin
						end
					endcase
				end
				ctb_pkg::CTB_MODE_SINGLE_SHOT: begin
					s_nxt.hold = s_r.hold & ~tick;
					if (s_r.run) begin
						if (tick) begin
							if (at_top) begin
								s_nxt.run = 1'b0;
								s_nxt.hold = 1'b1;
							end else begin
								s_nxt.count_value = inc16(s_r.count_value);
							end
						end
					end else if (shot_trig && !s_r.hold) begin
						s_nxt.count_value = 16'h0000;
						s_nxt.run = 1'b1;
					end
				end
				ctb_pkg::CTB_MODE_PWM8: begin
					if (tick) begin
						if (s_r.count_value[7:0] >= s_r.compare_capture_value[7:0]) begin
							s_nxt.count_value = 16'h0000;
						end else begin
							s_nxt.count_value = inc16(s_r.count_value);
						end
					end
				end
				default: begin
				end
			endcase
			if (s_r.restart_with_partner_timer && partner_restart_i) begin
				s_nxt.count_value = 16'h0000;
			end
		end else begin
			s_nxt.hold = 1'b0;
			s_nxt.run = 1'b0;
		end

		// Register writes
		s_nxt.rdata = 8'h00;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`CTB_OFS_CTRL_A: begin
					s_nxt.enable = reg_wdata_i[`CTB_BIT_ENABLE];
					s_nxt.clock_source_select = reg_wdata_i[`CTB_BIT_CLK_SEL_LO +: 2];
					s_nxt.restart_with_partner_timer = reg_wdata_i[`CTB_BIT_RESTART_PARTNER];
					// Starts without a trigger unless count already at top
					if (reg_wdata_i[`CTB_BIT_ENABLE] && !s_r.enable && mode == ctb_pkg::CTB_MODE_SINGLE_SHOT &&
						!at_top) begin
						s_nxt.run = 1'b1;
					end
				end
				`CTB_OFS_CTRL_B: begin
					s_nxt.timer_mode_select = reg_wdata_i[`CTB_BIT_MODE_LO +: 3];
					s_nxt.output_drive_enable = reg_wdata_i[`CTB_BIT_OUT_DRIVE_EN];
					s_nxt.output_initial_level = reg_wdata_i[`CTB_BIT_OUT_INIT];
					s_nxt.unclocked_event_detect = reg_wdata_i[`CTB_BIT_UNCLOCKED];
				end
				`CTB_OFS_EVENT_CTRL: begin
					s_nxt.event_input_enable = reg_wdata_i[`CTB_BIT_EVENT_EN];
					s_nxt.edge_sel = reg_wdata_i[`CTB_BIT_EDGE];
					s_nxt.filter_en = reg_wdata_i[`CTB_BIT_FILTER];
				end
				`CTB_OFS_IRQ_CTRL: s_nxt.irq_en = reg_wdata_i[`CTB_BIT_FLAG];
				`CTB_OFS_IRQ_FLAGS: flag_clr = reg_wdata_i[`CTB_BIT_FLAG];
				`CTB_OFS_STATUS: begin
					if (mode == ctb_pkg::CTB_MODE_TIMEOUT && s_r.run) begin
						s_nxt.run = reg_wdata_i[`CTB_BIT_RUN];
					end
				end
				`CTB_OFS_TEMP: s_nxt.temp = reg_wdata_i;
				`CTB_OFS_COUNT_LO: s_nxt.temp = reg_wdata_i;
				`CTB_OFS_COUNT_HI: s_nxt.count_value = {reg_wdata_i, s_r.temp};
				`CTB_OFS_COMPARE_LO: s_nxt.temp = reg_wdata_i;
				`CTB_OFS_COMPARE_HI: s_nxt.compare_capture_value = {reg_wdata_i, s_r.temp};
				default: begin
				end
			endcase
		end

		// Register reads; low byte latches the high byte for an atomic pair, except while a timeout is stopped
		if (reg_rd_i) begin
			case (reg_addr_i)
				`CTB_OFS_CTRL_A: s_nxt.rdata = {3'h0, s_r.restart_with_partner_timer, 1'b0,
					s_r.clock_source_select, s_r.enable};
				`CTB_OFS_CTRL_B: s_nxt.rdata = {1'b0, s_r.unclocked_event_detect, s_r.output_initial_level,
					s_r.output_drive_enable, 1'b0, s_r.timer_mode_select};
				`CTB_OFS_EVENT_CTRL: s_nxt.rdata = {1'b0, s_r.filter_en, 1'b0, s_r.edge_sel, 3'h0,
					s_r.event_input_enable};
				`CTB_OFS_IRQ_CTRL: s_nxt.rdata = {7'h00, s_r.irq_en};
				`CTB_OFS_IRQ_FLAGS: s_nxt.rdata = {7'h00, s_r.irq_flag};
				`CTB_OFS_STATUS: s_nxt.rdata = {7'h00, s_r.run};
				`CTB_OFS_TEMP: s_nxt.rdata = s_r.temp;
				`CTB_OFS_COUNT_LO: begin
					s_nxt.rdata = s_r.count_value[7:0];
					if (!frozen) begin
						s_nxt.temp = s_r.count_value[15:8];
					end
				end
				`CTB_OFS_COUNT_HI: s_nxt.rdata = s_r.temp;
				`CTB_OFS_COMPARE_LO: begin
					s_nxt.rdata = s_r.compare_capture_value[7:0];
					if (!frozen) begin
						s_nxt.temp = s_r.compare_capture_value[15:8];
					end
				end
				`CTB_OFS_COMPARE_HI: s_nxt.rdata = s_r.temp;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		if (rd_cmp_hi && capture_mode) begin
			flag_clr = 1'b1;
		end

		// Clearing re-arms the combined sequence
		if (flag_clr && mode == ctb_pkg::CTB_MODE_CAPT_FREQ_PW && !flag_set) begin
			s_nxt.fp_phase = ctb_pkg::CTB_FP_ARMED;
		end
		// A set in the same cycle as a clear wins
		if (flag_set) begin
			s_nxt.irq_flag = 1'b1;
		end else if (flag_clr) begin
			s_nxt.irq_flag = 1'b0;
		end
		s_nxt.event_out = flag_set;

		// Output stage; the unclocked path shows the start one clock early
		if (!s_r.output_drive_enable) begin
			s_nxt.wave = 1'b0;
		end else if (mode == ctb_pkg::CTB_MODE_SINGLE_SHOT) begin
			s_nxt.wave = s_r.unclocked_event_detect ? s_nxt.run : s_r.run;
		end else if (mode == ctb_pkg::CTB_MODE_PWM8) begin
			s_nxt.wave = s_r.enable & pwm_level;
		end else begin
			s_nxt.wave = s_r.output_initial_level;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_o = s_r.rdata;
	assign wave_o = s_r.wave;
	assign event_o = s_r.event_out;
	assign irq_o = s_r.irq_flag & s_r.irq_en;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_shot_running;
		mode == ctb_pkg::CTB_MODE_SINGLE_SHOT && s_r.enable && s_r.run;
	endsequence

	sequence s_shot_reaches_top;
		s_shot_running ##0 (tick && at_top);
	endsequence

	a_periodic_wrap: assert property ((mode == ctb_pkg::CTB_MODE_PERIODIC && tick && at_top && !reg_wr_i)
		|=> (s_r.count_value == 16'h0000 && s_r.irq_flag)) else $error("periodic wrap missed");
	a_capture_copy: assert property ((mode == ctb_pkg::CTB_MODE_CAPT_EVENT && s_r.enable && cap_evt && !reg_wr_i)
		|=> (s_r.compare_capture_value == $past(s_r.count_value) && s_r.irq_flag)) else $error("capture lost");
	a_freq_restart: assert property ((mode == ctb_pkg::CTB_MODE_CAPT_FREQ && s_r.enable && cap_evt && !reg_wr_i)
		|=> (s_r.count_value == 16'h0000 && event_o)) else $error("frequency restart missed");
	a_flag_read_clr: assert property ((capture_mode && rd_cmp_hi && !flag_set && !reg_wr_i)
		|=> !s_r.irq_flag) else $error("flag not cleared by read");
	a_shot_stop: assert property (s_shot_reaches_top |=> (!s_r.run && s_r.hold)) else $error("single shot overran");
	a_shot_wave: assert property ((s_shot_running ##0 (s_r.output_drive_enable && !s_r.unclocked_event_detect))
		|=> wave_o) else $error("single shot output low");
	a_pwm_zero: assert property ((mode == ctb_pkg::CTB_MODE_PWM8 && s_r.compare_capture_value[15:8] == 8'h00)
		|=> !wave_o) else $error("pwm output high at zero duty");
	a_init_level: assert property ((mode < ctb_pkg::CTB_MODE_SINGLE_SHOT && s_r.output_drive_enable)
		|=> wave_o == $past(s_r.output_initial_level)) else $error("initial level not driven");
	a_filter_pass: assert property ((s_r.filter_en && s_r.filt == `CTB_FILTER_ALL_HIGH) |=> s_r.filt_out)
		else $error("filter did not pass stable high");
	a_irq_follow: assert property ((flag_set && s_r.irq_en && !reg_wr_i)
		|=> irq_o ##1 (irq_o || $past(flag_clr || reg_wr_i))) else $error("irq request dropped");
	a_partner_restart: assert property ((s_r.enable && s_r.restart_with_partner_timer && partner_restart_i && !reg_wr_i)
		|=> s_r.count_value == 16'h0000) else $error("partner restart ignored");

endmodule
`default_nettype wire

/* ctb_consts.svh */
`ifndef CTB_CONSTS_SVH
`define CTB_CONSTS_SVH

// Register offsets, byte wide
`define CTB_OFS_CTRL_A 4'h0
`define CTB_OFS_CTRL_B 4'h1
`define CTB_OFS_EVENT_CTRL 4'h4
`define CTB_OFS_IRQ_CTRL 4'h5
`define CTB_OFS_IRQ_FLAGS 4'h6
`define CTB_OFS_STATUS 4'h7
`define CTB_OFS_TEMP 4'h9
`define CTB_OFS_COUNT_LO 4'ha
`define CTB_OFS_COUNT_HI 4'hb
`define CTB_OFS_COMPARE_LO 4'hc
`define CTB_OFS_COMPARE_HI 4'hd

// Field positions
`define CTB_BIT_ENABLE 0
`define CTB_BIT_CLK_SEL_LO 1
`define CTB_BIT_RESTART_PARTNER 4
`define CTB_BIT_MODE_LO 0
`define CTB_BIT_OUT_DRIVE_EN 4
`define CTB_BIT_OUT_INIT 5
`define CTB_BIT_UNCLOCKED 6
`define CTB_BIT_EVENT_EN 0
`define CTB_BIT_EDGE 4
`define CTB_BIT_FILTER 6
`define CTB_BIT_FLAG 0
`define CTB_BIT_RUN 0

// Clock source codes
`define CTB_CLK_PER 2'h0
`define CTB_CLK_PER_DIV2 2'h1
`define CTB_CLK_PARTNER 2'h2

// Noise filter samples
`define CTB_FILTER_ALL_HIGH 4'hf
`define CTB_FILTER_ALL_LOW 4'h0

`endif

/* ctb_partner_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ctb_partner_model (
	// Clock
	input wire logic mclk_i,
	// Toward the timer
	output logic event_o,
	output logic tick_o,
	output logic restart_o
);
	int tick_cnt = 0;
	initial begin
		event_o = 1'b0;
		tick_o = 1'b0;
		restart_o = 1'b0;
	end
	// Prescaled tick, one pulse in four clocks
	always @(posedge mclk_i) begin
		tick_cnt <= (tick_cnt + 1) % 4;
		tick_o <= (tick_cnt == 3);
	end
	// Levels stand whole cycles; callers never hold one below two
	task automatic evt(input logic v, input int n);
		@(posedge mclk_i);
		event_o <= v;
		repeat (n - 1) @(posedge mclk_i);
	endtask
	task automatic restart();
		@(posedge mclk_i);
		restart_o <= 1'b1;
		@(posedge mclk_i);
		restart_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* ctb_pkg.sv */
package ctb_pkg;

	typedef enum logic [2:0] {
		CTB_MODE_PERIODIC,
		CTB_MODE_TIMEOUT,
		CTB_MODE_CAPT_EVENT,
		CTB_MODE_CAPT_FREQ,
		CTB_MODE_CAPT_PW,
		CTB_MODE_CAPT_FREQ_PW,
		CTB_MODE_SINGLE_SHOT,
		CTB_MODE_PWM8
	} ctb_mode_t;

	typedef enum logic [1:0] {
		CTB_FP_ARMED,
		CTB_FP_COUNTING,
		CTB_FP_CAPTURED,
		CTB_FP_DONE
	} ctb_fp_phase_t;

	typedef struct packed {
		logic enable;
		logic [1:0] clock_source_select;
		logic restart_with_partner_timer;
		logic [2:0] timer_mode_select;
		logic output_drive_enable;
		logic output_initial_level;
		logic unclocked_event_detect;
		logic event_input_enable;
		logic edge_sel;
		logic filter_en;
		logic irq_en;
		logic irq_flag;
		logic run;
		logic hold;
		ctb_fp_phase_t fp_phase;
		logic div;
		logic [15:0] count_value;
		logic [15:0] compare_capture_value;
		logic [7:0] temp;
		logic [1:0] sync;
		logic [3:0] filt;
		logic filt_out;
		logic prev;
		logic wave;
		logic event_out;
		logic [7:0] rdata;
	} ctb_state_t;

endpackage

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctb_consts.svh"
module tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic event_i;
	logic tick;
	logic restart;
	logic event_o;
	logic wave_o;
	logic irq_o;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int n_strobe = 0;
	int n_wave = 0;
	logic [7:0] d;
	logic [7:0] x;
	logic [15:0] c1;
	logic [15:0] c2;

	always #2 mclk_i = ~mclk_i;

	ctb_capture_timer DUT (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .event_i(event_i), .partner_tick_i(tick),
		.partner_restart_i(restart), .event_o(event_o), .wave_o(wave_o), .irq_o(irq_o));
	ctb_partner_model PM (.mclk_i(mclk_i), .event_o(event_i), .tick_o(tick), .restart_o(restart));

	always @(posedge mclk_i) begin
		cyc++;
		if (event_o === 1'b1) n_strobe++;
		if (wave_o === 1'b1) n_wave++;
		if (cyc == 30000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		v = reg_rdata_o;
	endtask
	// Low byte first: it moves the low byte through the holding register
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 4'h1, v[15:8]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic t_reset();
		chk(irq_o, 1'b0);
		chk(wave_o, 1'b0);
		for (int m = 0; m < 8; m++) begin
			wr(`CTB_OFS_CTRL_B, 8'(m));
			rd(`CTB_OFS_CTRL_B, d);
			chk(d, 8'(m));
		end
		wr(4'h2, 8'hff);
		rd(4'h2, d);
		chk(d, 8'h00);
	endtask

	task automatic t_periodic();
		wr(`CTB_OFS_CTRL_B, 8'h00);
		wr16(`CTB_OFS_COMPARE_LO, 16'd20);
		wr(`CTB_OFS_IRQ_CTRL, 8'h01);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		cycles(25);
		chk(irq_o, 1'b1);
		wr(`CTB_OFS_IRQ_FLAGS, 8'h01);
		@(negedge mclk_i);
		chk(irq_o, 1'b0);
		// Two full periods of 21 apart give the same count
		rd(`CTB_OFS_COUNT_LO, x);
		cycles(40);
		rd(`CTB_OFS_COUNT_LO, d);
		chk(d, x);
		wr(`CTB_OFS_IRQ_CTRL, 8'h00);
		cycles(25);
		chk(irq_o, 1'b0);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h01);
		// Compare below the count: run through the wrap before flagging
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_IRQ_FLAGS, 8'h01);
		wr16(`CTB_OFS_COMPARE_LO, 16'd5);
		wr16(`CTB_OFS_COUNT_LO, 16'hfff0);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		cycles(8);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h00);
		cycles(20);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h01);
		wr(`CTB_OFS_IRQ_CTRL, 8'h01);
	endtask

	task automatic t_capture();
		int s0;
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h02);
		wr(`CTB_OFS_EVENT_CTRL, 8'h11);
		wr(`CTB_OFS_IRQ_FLAGS, 8'h01);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		s0 = n_strobe;
		fork
			begin
				PM.evt(1'b1, 10);
				PM.evt(1'b0, 70);
				PM.evt(1'b1, 10);
				PM.evt(1'b0, 30);
			end
			begin
				cycles(30);
				chk(irq_o, 1'b1);
				rd16(`CTB_OFS_COMPARE_LO, c1);
				rd(`CTB_OFS_IRQ_FLAGS, d);
				chk(d, 8'h00);
			end
		join
		rd16(`CTB_OFS_COMPARE_LO, c2);
		chk(c2 - c1, 16'd80);
		chk(n_strobe - s0, 16'd2);
		wr(`CTB_OFS_EVENT_CTRL, 8'h10);
		PM.evt(1'b1, 5);
		PM.evt(1'b0, 10);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h00);
		// Three low samples are a glitch, not an edge
		wr(`CTB_OFS_EVENT_CTRL, 8'h51);
		PM.evt(1'b1, 8);
		PM.evt(1'b0, 3);
		PM.evt(1'b1, 8);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h00);
		PM.evt(1'b0, 12);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h01);
	endtask

	task automatic t_freq();
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h03);
		wr(`CTB_OFS_EVENT_CTRL, 8'h01);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		fork
			begin
				PM.evt(1'b1, 10);
				PM.evt(1'b0, 20);
				PM.evt(1'b1, 10);
				PM.evt(1'b0, 40);
				PM.evt(1'b1, 10);
				PM.evt(1'b0, 10);
			end
			begin
				cycles(45);
				rd16(`CTB_OFS_COMPARE_LO, c1);
			end
		join
		rd16(`CTB_OFS_COMPARE_LO, c2);
		chk(c2 - c1, 16'd20);
	endtask

	task automatic t_measure();
		// Timeout: first rise starts, second rise freezes
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h01);
		wr(`CTB_OFS_EVENT_CTRL, 8'h01);
		wr16(`CTB_OFS_COMPARE_LO, 16'd20);
		wr(`CTB_OFS_IRQ_FLAGS, 8'h01);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		PM.evt(1'b1, 10);
		PM.evt(1'b0, 40);
		PM.evt(1'b1, 10);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h01);
		rd(`CTB_OFS_COUNT_LO, x);
		cycles(5);
		rd(`CTB_OFS_COUNT_LO, d);
		chk(d, x);
		wr(`CTB_OFS_STATUS, 8'h01);
		rd(`CTB_OFS_STATUS, d);
		chk(d, 8'h00);
		PM.evt(1'b0, 5);
		PM.evt(1'b1, 10);
		rd(`CTB_OFS_STATUS, d);
		chk(d, 8'h01);
		// Pulse width: two pulses 15 clocks apart in length
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h04);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		PM.evt(1'b0, 10);
		PM.evt(1'b1, 25);
		PM.evt(1'b0, 20);
		rd16(`CTB_OFS_COMPARE_LO, c1);
		PM.evt(1'b1, 40);
		PM.evt(1'b0, 20);
		rd16(`CTB_OFS_COMPARE_LO, c2);
		chk(c2 - c1, 16'd15);
		// Combined: 30 clocks high, stop on second rise
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h05);
		wr(`CTB_OFS_IRQ_FLAGS, 8'h01);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		PM.evt(1'b1, 30);
		PM.evt(1'b0, 20);
		PM.evt(1'b1, 10);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h01);
		rd(`CTB_OFS_COUNT_LO, x);
		cycles(5);
		rd(`CTB_OFS_COUNT_LO, d);
		chk(d, x);
		rd16(`CTB_OFS_COMPARE_LO, c2);
		chk(c2 - c1, 16'd5);
		rd(`CTB_OFS_IRQ_FLAGS, d);
		chk(d, 8'h00);
		// Re-armed: a fall is ignored, the next rise zeroes the count
		PM.evt(1'b0, 10);
		PM.evt(1'b1, 10);
		rd(`CTB_OFS_COUNT_LO, d);
		chk(d < 8'd20, 1'b1);
		PM.evt(1'b0, 10);
	endtask

	task automatic t_single();
		int w0;
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h16);
		wr(`CTB_OFS_EVENT_CTRL, 8'h01);
		wr16(`CTB_OFS_COUNT_LO, 16'd10);
		wr16(`CTB_OFS_COMPARE_LO, 16'd10);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		cycles(5);
		chk(wave_o, 1'b0);
		fork
			PM.evt(1'b1, 30);
			begin
				cycles(4);
				@(negedge mclk_i);
				chk(wave_o, 1'b0);
				@(negedge mclk_i);
				chk(wave_o, 1'b1);
				rd(`CTB_OFS_STATUS, d);
				chk(d, 8'h01);
			end
		join
		chk(wave_o, 1'b0);
		rd(`CTB_OFS_STATUS, d);
		chk(d, 8'h00);
		w0 = n_wave;
		PM.evt(1'b0, 30);
		chk(n_wave - w0, 16'd0);
		wr(`CTB_OFS_EVENT_CTRL, 8'h11);
		PM.evt(1'b1, 30);
		w0 = n_wave;
		PM.evt(1'b0, 30);
		chk(n_wave > w0, 16'd1);
		// Count away from top: enabling starts a shot by itself
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr16(`CTB_OFS_COUNT_LO, 16'h0000);
		wr(`CTB_OFS_CTRL_A, 8'h01);
		rd(`CTB_OFS_STATUS, d);
		chk(d, 8'h01);
	endtask

	task automatic t_pwm();
		logic [7:0] lo[5] = '{8'd9, 8'd9, 8'd9, 8'd9, 8'd0};
		logic [7:0] hi[5] = '{8'd3, 8'd9, 8'd10, 8'd0, 8'd5};
		int exp[5] = '{30, 90, 100, 0, 0};
		int w0;
		for (int i = 0; i < 5; i++) begin
			// Stop, load both bytes, zero the count, restart
			wr(`CTB_OFS_CTRL_A, 8'h00);
			wr(`CTB_OFS_CTRL_B, 8'h17);
			wr16(`CTB_OFS_COMPARE_LO, {hi[i], lo[i]});
			wr16(`CTB_OFS_COUNT_LO, 16'h0000);
			wr(`CTB_OFS_CTRL_A, 8'h01);
			cycles(5);
			w0 = n_wave;
			cycles(100);
			chk(n_wave - w0, 16'(exp[i]));
		end
	endtask

	task automatic t_level();
		wr(`CTB_OFS_CTRL_A, 8'h00);
		wr(`CTB_OFS_CTRL_B, 8'h30);
		cycles(2);
		chk(wave_o, 1'b1);
		wr(`CTB_OFS_CTRL_B, 8'h20);
		cycles(2);
		chk(wave_o, 1'b0);
	endtask

	task automatic t_partner();
		wr16(`CTB_OFS_COMPARE_LO, 16'hffff);
		wr16(`CTB_OFS_COUNT_LO, 16'h0000);
		wr(`CTB_OFS_CTRL_B, 8'h00);
		wr(`CTB_OFS_CTRL_A, 8'h15);
		rd(`CTB_OFS_COUNT_LO, x);
		cycles(38);
		rd(`CTB_OFS_COUNT_LO, d);
		chk(8'(d - x), 8'd10);
		PM.restart();
		rd(`CTB_OFS_COUNT_LO, d);
		chk(d < 8'd2, 1'b1);
	endtask

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_periodic();
		t_capture();
		t_freq();
		t_measure();
		t_single();
		t_pwm();
		t_level();
		t_partner();
		give_verdict();
	end
endmodule
`default_nettype wire
